//--- csc_top.sv
`timescale 1ns/100ps
// Overview of operation
// - freq select bit picks frequency set
// - pair select bit picks pair state
// - primary select bit picks primary state
// - pins 1,2 serial unless nvm bit set
// - control-pin mode mutes serial, supply low overrides
// - pin 0 is always a control input
// - power-up loads configuration from nonvolatile store
// - factory default: pin 0 toggles hi-z/active
// - serial mode decodes pins 1,2 as zero
// - 7-bit slave, standard and fast mode
// - byte/block read and write transactions
// - block bytes ascending, msb first, any stop
// - block read returns byte-count bytes
// - each written byte applies at once
// - nvm write copies regs, refuses writes, busy
// - command code byte gives register offset
// - address 11001 plus two programmable bits
// - address lsb: 1 read, 0 write
// - eight settings chosen by pins 2,1,0
// - 3-bit spread field, center/down option
module csc_top #(
	parameter int NVM_WRITE_CYCLES = csc_pkg::NVM_WRITE_US * csc_pkg::CLK_MHZ
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ctrl_pin_0_i,
	input wire logic ctrl_pin_1_i,
	input wire logic ctrl_pin_2_i,
	input wire logic output_supply_low_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic freq_select_bit_o,
	output logic [2:0] spread_select_field_o,
	output logic spread_center_o,
	output logic pll_bypass_o,
	output logic [1:0] pll_output_pair_o,
	output logic [1:0] primary_output_o,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o
);

	// ------------------------------------------------------------
	// storage and state
	// ------------------------------------------------------------
	logic [7:0] cfg_reg [csc_pkg::NREG];
	logic [7:0] nvm_reg [csc_pkg::NREG];
	logic [2:0] p0_sync_reg, p1_sync_reg, p2_sync_reg, sup_sync_reg;
	logic load_reg;
	logic busy_reg;
	logic [31:0] busy_cnt_reg;
	logic serial_act_reg;
	logic [2:0] act_idx_reg;
	csc_pkg::csc_state_e st_reg;
	csc_pkg::csc_kind_e kind_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg, tx_reg, remain_reg;
	logic [3:0] ptr_reg;
	logic rd_reg, byte_op_reg;
	logic ser_we_reg;
	logic [3:0] ser_idx_reg;
	logic [7:0] ser_wdata_reg;
	logic sda_oe_n_reg;
	logic pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;
	logic nvm_go;
	logic apb_cfg_we;
	logic [3:0] apb_idx;
	logic [7:0] sel_byte;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic sda_s, scl_s;
	logic [7:0] rx_byte;
	logic addr_match;

	// read value of a config byte; busy flag overlays its bit
	function automatic logic [7:0] rd_byte(input logic [3:0] i);
		logic [7:0] v;
		v = cfg_reg[i];
		if (i == csc_pkg::OFS_ADDR) begin
			v[csc_pkg::BIT_BUSY] = busy_reg;
			v[csc_pkg::BIT_NVM_GO] = 1'b0;
		end
		return v;
	endfunction

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// third stage is only an edge history, the first stage feeds the second alone
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			p0_sync_reg <= 3'h0;
			p1_sync_reg <= 3'h7;
			p2_sync_reg <= 3'h7;
			sup_sync_reg <= 3'h0;
		end else begin
			p0_sync_reg <= {p0_sync_reg[1:0], ctrl_pin_0_i};
			p1_sync_reg <= {p1_sync_reg[1:0], ctrl_pin_1_i};
			p2_sync_reg <= {p2_sync_reg[1:0], ctrl_pin_2_i};
			sup_sync_reg <= {sup_sync_reg[1:0], output_supply_low_i};
		end
	end

	assign sda_s = p1_sync_reg[1];
	assign scl_s = p2_sync_reg[1];
	assign scl_rise = scl_s && !p2_sync_reg[2];
	assign scl_fall = !scl_s && p2_sync_reg[2];
	assign start_det = scl_s && p2_sync_reg[2] && !sda_s && p1_sync_reg[2];
	assign stop_det = scl_s && p2_sync_reg[2] && sda_s && !p1_sync_reg[2];
	assign rx_byte = shift_reg;
	assign addr_match = rx_byte[7:1] == {csc_pkg::SLAVE_ADDR_HI, cfg_reg[csc_pkg::OFS_ADDR][1:0]};

	// ------------------------------------------------------------
	// pin mode and setting index
	// ------------------------------------------------------------
	// pin mode follows the committed nvm copy only, so a register-only change cannot lock software out
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			serial_act_reg <= 1'b1;
			act_idx_reg <= 3'h0;
		end else begin
			serial_act_reg <= !nvm_reg[csc_pkg::OFS_MODE][csc_pkg::BIT_PINCTRL] || sup_sync_reg[1];
			if (serial_act_reg) begin
				act_idx_reg <= {2'b00, p0_sync_reg[1]};
			end else begin
				act_idx_reg <= {p2_sync_reg[1], p1_sync_reg[1], p0_sync_reg[1]};
			end
		end
	end

	assign sel_byte = cfg_reg[csc_pkg::OFS_SET0 + {1'b0, act_idx_reg}];

	// ------------------------------------------------------------
	// setting decode to the analog controls
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			freq_select_bit_o <= 1'b0;
			spread_select_field_o <= 3'h0;
			spread_center_o <= 1'b0;
			pll_bypass_o <= 1'b1;
			pll_output_pair_o <= csc_pkg::OST_HIZ;
			primary_output_o <= csc_pkg::OST_HIZ;
		end else begin
			freq_select_bit_o <= sel_byte[csc_pkg::BIT_FS];
			spread_select_field_o <= sel_byte[3:1];
			spread_center_o <= cfg_reg[csc_pkg::OFS_PLL][csc_pkg::BIT_CENTER];
			pll_bypass_o <= cfg_reg[csc_pkg::OFS_PLL][csc_pkg::BIT_BYPASS];
			pll_output_pair_o <= sel_byte[csc_pkg::BIT_PAIR] ? cfg_reg[csc_pkg::OFS_PLL][5:4]
				: cfg_reg[csc_pkg::OFS_PLL][3:2];
			primary_output_o <= sel_byte[csc_pkg::BIT_PRIM] ? cfg_reg[csc_pkg::OFS_MODE][3:2]
				: cfg_reg[csc_pkg::OFS_MODE][1:0];
		end
	end

	// ------------------------------------------------------------
	// configuration bytes and nonvolatile copy
	// ------------------------------------------------------------
	// the apb start lands on the completing edge, where the master samples ready high
	assign nvm_go = (ser_we_reg && ser_idx_reg == csc_pkg::OFS_ADDR && ser_wdata_reg[csc_pkg::BIT_NVM_GO])
		|| (pready_reg && psel_i && penable_i && pwrite_i && paddr_i == csc_pkg::APB_CTRL && pwdata_i[0]);

	// power-up copies the store into the live bytes one cycle after reset release
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			load_reg <= 1'b1;
			for (int i = 0; i < csc_pkg::NREG; i++) begin
				cfg_reg[i] <= 8'h00;
			end
		end else begin
			load_reg <= 1'b0;
			if (load_reg) begin
				for (int i = 0; i < csc_pkg::NREG; i++) begin
					cfg_reg[i] <= nvm_reg[i];
				end
			end else if (ser_we_reg) begin
				cfg_reg[ser_idx_reg] <= ser_wdata_reg;
			end else if (apb_cfg_we) begin
				cfg_reg[apb_idx] <= pwdata_i[7:0];
			end
		end
	end

	// the store is the flip-flop model of the eeprom; reset models a power cycle
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_reg <= 1'b0;
			busy_cnt_reg <= 32'h0;
			for (int i = 0; i < csc_pkg::NREG; i++) begin
				nvm_reg[i] <= csc_pkg::factory_byte(4'(i));
			end
		end else if (busy_reg) begin
			if (busy_cnt_reg == 32'(NVM_WRITE_CYCLES - 1)) begin
				busy_reg <= 1'b0;
				busy_cnt_reg <= 32'h0;
				for (int i = 0; i < csc_pkg::NREG; i++) begin
					nvm_reg[i] <= cfg_reg[i];
				end
			end else begin
				busy_cnt_reg <= busy_cnt_reg + 32'h1;
			end
		end else if (nvm_go && !load_reg) begin
			busy_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// serial slave
	// ------------------------------------------------------------
	// open drain: only a low is ever driven
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= csc_pkg::ST_IDLE;
			kind_reg <= csc_pkg::K_ADDR;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			remain_reg <= 8'h00;
			ptr_reg <= 4'h0;
			rd_reg <= 1'b0;
			byte_op_reg <= 1'b0;
			ser_we_reg <= 1'b0;
			ser_idx_reg <= 4'h0;
			ser_wdata_reg <= 8'h00;
			sda_oe_n_reg <= 1'b1;
		end else begin
			ser_we_reg <= 1'b0;
			if (!serial_act_reg) begin
				st_reg <= csc_pkg::ST_IDLE;
				sda_oe_n_reg <= 1'b1;
			end else if (start_det) begin
				st_reg <= csc_pkg::ST_RECV;
				kind_reg <= csc_pkg::K_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe_n_reg <= 1'b1;
			end else if (stop_det) begin
				st_reg <= csc_pkg::ST_IDLE;
				sda_oe_n_reg <= 1'b1;
			end else begin
				case (st_reg)
					csc_pkg::ST_RECV: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall && bit_cnt_reg == 4'h8) begin
							bit_cnt_reg <= 4'h0;
							st_reg <= csc_pkg::ST_ACK;
							sda_oe_n_reg <= 1'b0;
							case (kind_reg)
								csc_pkg::K_ADDR: begin
									if (!addr_match) begin
										st_reg <= csc_pkg::ST_IDLE;
										sda_oe_n_reg <= 1'b1;
									end else if (rx_byte[0]) begin
										rd_reg <= 1'b1;
										tx_reg <= rd_byte(ptr_reg);
										remain_reg <= byte_op_reg ? 8'h01 : cfg_reg[csc_pkg::OFS_COUNT];
									end else begin
										rd_reg <= 1'b0;
										kind_reg <= csc_pkg::K_CMD;
									end
								end
								csc_pkg::K_CMD: begin
									ptr_reg <= rx_byte[3:0];
									byte_op_reg <= rx_byte[csc_pkg::BIT_BYTE_OP];
									remain_reg <= 8'h01;
									kind_reg <= rx_byte[csc_pkg::BIT_BYTE_OP] ? csc_pkg::K_DATA : csc_pkg::K_COUNT;
								end
								csc_pkg::K_COUNT: begin
									remain_reg <= rx_byte;
									kind_reg <= csc_pkg::K_DATA;
								end
								default: begin
									// refused bytes get a nack and are dropped
									if (busy_reg || remain_reg == 8'h00) begin
										sda_oe_n_reg <= 1'b1;
									end else begin
										ser_we_reg <= 1'b1;
										ser_idx_reg <= ptr_reg;
										ser_wdata_reg <= rx_byte;
										ptr_reg <= ptr_reg + 4'h1;
										remain_reg <= remain_reg - 8'h01;
									end
								end
							endcase
						end
					end
					csc_pkg::ST_ACK: begin
						if (scl_fall) begin
							if (rd_reg) begin
								st_reg <= csc_pkg::ST_SEND;
								sda_oe_n_reg <= tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'b0};
								bit_cnt_reg <= 4'h1;
							end else begin
								st_reg <= csc_pkg::ST_RECV;
								sda_oe_n_reg <= 1'b1;
								bit_cnt_reg <= 4'h0;
							end
						end
					end
					csc_pkg::ST_SEND: begin
						if (scl_fall) begin
							if (bit_cnt_reg == 4'h8) begin
								st_reg <= csc_pkg::ST_RACK;
								sda_oe_n_reg <= 1'b1;
							end else begin
								sda_oe_n_reg <= tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					csc_pkg::ST_RACK: begin
						if (scl_rise) begin
							// ack with bytes left: next byte; otherwise wait for stop
							if (!sda_s && remain_reg > 8'h01) begin
								st_reg <= csc_pkg::ST_ACK;
								ptr_reg <= ptr_reg + 4'h1;
								remain_reg <= remain_reg - 8'h01;
								tx_reg <= rd_byte(ptr_reg + 4'h1);
							end else begin
								st_reg <= csc_pkg::ST_IDLE;
								ptr_reg <= ptr_reg + 4'h1;
							end
						end
					end
					default: begin
						sda_oe_n_reg <= 1'b1;
					end
				endcase
			end
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_n_o = sda_oe_n_reg;

	// ------------------------------------------------------------
	// apb slave, one wait state
	// ------------------------------------------------------------
	assign apb_idx = paddr_i[5:2];
	// config writes from apb are also dropped while the store is busy; they land with ready high
	assign apb_cfg_we = pready_reg && psel_i && penable_i && pwrite_i && !busy_reg
		&& paddr_i >= csc_pkg::APB_CFG_BASE && paddr_i <= csc_pkg::APB_CFG_END && paddr_i[1:0] == 2'b00;

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= psel_i && penable_i && !pready_reg;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
			if (psel_i && penable_i && !pready_reg) begin
				if (paddr_i == csc_pkg::APB_STATUS) begin
					prdata_reg <= {26'h0, load_reg, busy_reg, serial_act_reg, act_idx_reg};
				end else if (paddr_i >= csc_pkg::APB_CFG_BASE && paddr_i <= csc_pkg::APB_CFG_END
					&& paddr_i[1:0] == 2'b00) begin
					prdata_reg <= {24'h0, rd_byte(apb_idx)};
				end else if (paddr_i != csc_pkg::APB_CTRL) begin
					pslverr_reg <= 1'b1;
				end
			end
		end
	end

	assign pready_o = pready_reg;
	assign prdata_o = prdata_reg;
	assign pslverr_o = pslverr_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_idle_released: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_reg == csc_pkg::ST_IDLE && $past(st_reg) == csc_pkg::ST_IDLE) |-> sda_oe_n_o)
		else $error("data line driven while idle");
	a_ctrl_mode_mute: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!serial_act_reg |=> sda_oe_n_o)
		else $error("serial port answered in control-pin mode");
	a_serial_index: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$past(serial_act_reg) |-> act_idx_reg[2:1] == 2'b00)
		else $error("pins 1,2 decoded while serial");
	a_freq_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		##1 freq_select_bit_o == $past(sel_byte[csc_pkg::BIT_FS]))
		else $error("frequency select mismatch");
	a_pair_state: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$past(sel_byte[csc_pkg::BIT_PAIR]) && !$past(load_reg)
		|-> pll_output_pair_o == $past(cfg_reg[csc_pkg::OFS_PLL][5:4]))
		else $error("pair state one not applied");
	a_prim_state: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!$past(sel_byte[csc_pkg::BIT_PRIM]) && !$past(load_reg)
		|-> primary_output_o == $past(cfg_reg[csc_pkg::OFS_MODE][1:0]))
		else $error("primary state zero not applied");
	a_spread_field: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		##1 spread_select_field_o == $past(sel_byte[3:1]))
		else $error("spread field mismatch");
	a_busy_refuse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		ser_we_reg |-> !$past(busy_reg))
		else $error("serial write taken while busy");
	a_busy_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(busy_reg) |-> busy_reg[*8])
		else $error("nvm cycle ended too soon");
	a_write_apply: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		ser_we_reg |=> cfg_reg[$past(ser_idx_reg)] == $past(ser_wdata_reg))
		else $error("written byte not applied");
	a_foreign_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_reg == csc_pkg::ST_RECV && kind_reg == csc_pkg::K_ADDR && scl_fall && bit_cnt_reg == 4'h8
		&& !addr_match && serial_act_reg && !start_det && !stop_det) |=> sda_oe_n_o ##1 sda_oe_n_o)
		else $error("acked a foreign address");

endmodule // csc_top

//--- csc_pkg.sv
package csc_pkg;

	// ------------------------------------------------------------
	// configuration byte map
	// ------------------------------------------------------------
	localparam int NREG = 16;
	localparam logic [3:0] OFS_ID = 4'h0;
	localparam logic [3:0] OFS_ADDR = 4'h1;
	localparam logic [3:0] OFS_MODE = 4'h2;
	localparam logic [3:0] OFS_COUNT = 4'h3;
	localparam logic [3:0] OFS_PLL = 4'h4;
	localparam logic [3:0] OFS_SET0 = 4'h5;

	// field positions
	localparam int BIT_BUSY = 6;
	localparam int BIT_NVM_GO = 5;
	localparam int BIT_PINCTRL = 6;
	localparam int BIT_BYPASS = 7;
	localparam int BIT_CENTER = 0;
	localparam int BIT_FS = 0;
	localparam int BIT_PAIR = 4;
	localparam int BIT_PRIM = 5;
	localparam int BIT_BYTE_OP = 7;

	// fixed upper part of the serial slave address
	localparam logic [4:0] SLAVE_ADDR_HI = 5'h19;

	// output state codes
	localparam logic [1:0] OST_PDN = 2'h0;
	localparam logic [1:0] OST_HIZ = 2'h1;
	localparam logic [1:0] OST_LOW = 2'h2;
	localparam logic [1:0] OST_ACT = 2'h3;

	// factory contents of the nonvolatile store
	localparam logic [7:0] RST_ID = 8'h5a; // arbitrary identity value
	localparam logic [7:0] RST_ADDR = 8'h01;
	localparam logic [7:0] RST_MODE = 8'h0d;
	localparam logic [7:0] RST_COUNT = 8'h10;
	localparam logic [7:0] RST_PLL = 8'hb4;
	localparam logic [7:0] RST_SET1 = 8'h30;

	// apb map
	localparam logic [11:0] APB_CTRL = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam logic [11:0] APB_CFG_BASE = 12'h040;
	localparam logic [11:0] APB_CFG_END = 12'h07c;

	// timing
	localparam int CLK_MHZ = 100;
	localparam int NVM_WRITE_US = 100;

	typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_RACK} csc_state_e;
	typedef enum logic [1:0] {K_ADDR, K_CMD, K_COUNT, K_DATA} csc_kind_e;

	function automatic logic [7:0] factory_byte(input logic [3:0] i);
		case (i)
			OFS_ID: factory_byte = RST_ID;
			OFS_ADDR: factory_byte = RST_ADDR;
			OFS_MODE: factory_byte = RST_MODE;
			OFS_COUNT: factory_byte = RST_COUNT;
			OFS_PLL: factory_byte = RST_PLL;
			4'h6: factory_byte = RST_SET1;
			default: factory_byte = 8'h00;
		endcase
	endfunction

endpackage

//--- csc_i2c_master.sv
`timescale 1ns/100ps
// --------
// two-wire bus controller model
// --------
module csc_i2c_master (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// both lines released between frames, the clock stands still
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// start or repeated start: data falls while the clock is high
	task automatic start_cond();
		sda_o <= 1'b1;
		wait_clk(4);
		scl_o <= 1'b1;
		wait_clk(8);
		sda_o <= 1'b0;
		wait_clk(8);
		scl_o <= 1'b0;
		wait_clk(4);
	endtask

	task automatic stop_cond();
		sda_o <= 1'b0;
		wait_clk(4);
		scl_o <= 1'b1;
		wait_clk(8);
		sda_o <= 1'b1;
		wait_clk(8);
	endtask

	// data moves mid-low so it never changes while the clock is high
	// fixed period of 16 clocks: one target on this bus, a crowded bus would stretch the waits
	task automatic bit_io(input logic b, output logic r);
		sda_o <= b;
		wait_clk(4);
		scl_o <= 1'b1;
		wait_clk(8);
		r = sda_i;
		scl_o <= 1'b0;
		wait_clk(4);
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask

	// a nack only after the final byte, so every counted byte is taken
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule // csc_i2c_master

//--- csc_top_test.sv
`timescale 1ns/100ps
module csc_top_test;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1, p0 = 1'b0, p1 = 1'b0, p2 = 1'b0, ser = 1'b1, sup_low = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nvm_pc;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic sda_d, sda_oe_n, freq, center, bypass, pready, pslverr, scl_m, sda_m, sda_line, pin1, pin2;
	logic [2:0] spread;
	logic [1:0] pair, prim;
	logic [7:0] cm [16];
	int bad_count = 0;
	int total_checks = 0;

	// open-drain data with pull-up; pins follow the master only in serial use
	assign sda_line = sda_m & (sda_oe_n | sda_d);
	assign pin1 = ser ? sda_line : p1;
	assign pin2 = ser ? scl_m : p2;
	always #5 mclk = ~mclk;

	csc_top #(.NVM_WRITE_CYCLES(2000)) dut (.mclk_i(mclk), .sys_rst_i(sys_rst), .ctrl_pin_0_i(p0),
		.ctrl_pin_1_i(pin1), .ctrl_pin_2_i(pin2), .output_supply_low_i(sup_low), .sda_o(sda_d),
		.sda_oe_n_o(sda_oe_n), .freq_select_bit_o(freq), .spread_select_field_o(spread),
		.spread_center_o(center), .pll_bypass_o(bypass), .pll_output_pair_o(pair), .primary_output_o(prim),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr));
	csc_i2c_master m (.clk_i(mclk), .sda_i(sda_line), .scl_o(scl_m), .sda_o(sda_m));

	// --------
	// helpers
	// --------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// no wait is assumed: the access phase lasts until ready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] cfg(input int i);
		cfg = csc_pkg::APB_CFG_BASE + 12'(4 * i);
	endfunction

	function automatic logic [7:0] adr(input logic rw);
		adr = {csc_pkg::SLAVE_ADDR_HI, cm[1][1:0], rw};
	endfunction

	// outputs expected from the model store for one setting index
	function automatic logic [9:0] exp_out(input logic [2:0] idx);
		logic [7:0] s;
		s = cm[5 + idx];
		exp_out = {s[0], s[3:1], cm[4][0], cm[4][7], s[4] ? cm[4][5:4] : cm[4][3:2], s[5] ? cm[2][3:2] : cm[2][1:0]};
	endfunction

	task automatic load_factory();
		foreach (cm[i]) cm[i] = 8'h00;
		cm[0] = csc_pkg::RST_ID;
		cm[1] = csc_pkg::RST_ADDR;
		cm[2] = csc_pkg::RST_MODE;
		cm[3] = csc_pkg::RST_COUNT;
		cm[4] = csc_pkg::RST_PLL;
		cm[6] = csc_pkg::RST_SET1;
		nvm_pc = 1'b0;
	endtask

	task automatic chk_state();
		logic [31:0] d;
		logic e;
		logic sa;
		logic [2:0] idx;
		repeat (8) @(posedge mclk);
		sa = !nvm_pc || sup_low;
		idx = sa ? {2'b00, p0} : {pin2, pin1, p0};
		apb(1'b0, csc_pkg::APB_STATUS, 0, d, e);
		chk(d[3:0], {sa, idx});
		chk({freq, spread, center, bypass, pair, prim}, exp_out(idx));
	endtask

	// stops at the first refused byte; n counts acknowledged bytes
	task automatic i2c_write(input logic [7:0] q[$], output int n);
		logic a;
		n = 0;
		m.start_cond();
		foreach (q[i]) begin
			m.send_byte(q[i], a);
			if (a !== 1'b1) break;
			n++;
		end
		m.stop_cond();
	endtask

	task automatic i2c_read(input logic [7:0] cmd, input int cnt, output logic [7:0] q[$]);
		logic a;
		logic [7:0] d;
		q = {};
		m.start_cond();
		m.send_byte(adr(1'b0), a);
		m.send_byte(cmd, a);
		m.start_cond();
		m.send_byte(adr(1'b1), a);
		chk(a, 1'b1);
		for (int i = 0; i < cnt; i++) begin
			m.recv_byte(i == cnt - 1, d);
			q.push_back(d);
		end
		m.stop_cond();
	endtask

	task automatic check_factory();
		logic [31:0] d;
		logic e;
		for (int i = 0; i < 13; i++) begin
			apb(1'b0, cfg(i), 0, d, e);
			chk(d, {24'h0, cm[i]});
		end
		apb(1'b0, 12'h080, 0, d, e);
		chk(e, 1'b1);
		for (int i = 0; i < 2; i++) begin
			p0 <= i[0];
			chk_state();
		end
	endtask

	// --------
	// scenarios
	// --------
	initial begin
		logic [31:0] d;
		logic e;
		logic [7:0] q[$];
		logic [7:0] r;
		int n;
		void'($urandom(43));
		load_factory();
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		check_factory();
		for (int i = 4; i < 13; i++) begin
			r = 8'($urandom);
			apb(1'b1, cfg(i), {24'h0, r}, d, e);
			cm[i] = r;
		end
		r = 8'($urandom);
		i2c_write({adr(1'b0), 8'h85, r}, n);
		cm[5] = r;
		chk(n, 3);
		chk_state();
		i2c_read(8'h85, 1, q);
		chk(q[0], cm[5]);
		// block write stopped one byte short of its count
		i2c_write({adr(1'b0), 8'h83, 8'h02}, n);
		cm[3] = 8'h02;
		r = 8'($urandom);
		i2c_write({adr(1'b0), 8'h06, 8'h03, r, ~r}, n);
		cm[6] = r;
		cm[7] = ~r;
		chk(n, 5);
		i2c_read(8'h06, 2, q);
		chk({q[0], q[1]}, {cm[6], cm[7]});
		apb(1'b1, cfg(1), 32'h2, d, e);
		i2c_write({adr(1'b0), 8'h85, 8'h00}, n);
		chk(n, 0);
		cm[1] = 8'h02;
		i2c_read(8'h81, 1, q);
		chk(q[0], cm[1]);
		cm[2] = cm[2] | 8'h40;
		apb(1'b1, cfg(2), {24'h0, cm[2]}, d, e);
		chk_state();
		// save with the output supply held low keeps the serial port alive
		sup_low <= 1'b1;
		apb(1'b1, csc_pkg::APB_CTRL, 32'h1, d, e);
		nvm_pc = 1'b1;
		apb(1'b0, csc_pkg::APB_STATUS, 0, d, e);
		chk(d[4], 1'b1);
		apb(1'b0, cfg(1), 0, d, e);
		chk(d, {24'h0, cm[1] | 8'h40});
		i2c_write({adr(1'b0), 8'h85, 8'h00}, n);
		chk(n, 2);
		i2c_read(8'h85, 1, q);
		chk(q[0], cm[5]);
		n = 0;
		do begin
			apb(1'b0, csc_pkg::APB_STATUS, 0, d, e);
			n++;
		end while (d[4] !== 1'b0 && n < 1000);
		chk(d[4], 1'b0);
		sup_low <= 1'b0;
		chk_state();
		i2c_write({adr(1'b0), 8'h85, 8'h00}, n);
		chk(n, 0);
		ser <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			{p2, p1, p0} <= 3'(i);
			chk_state();
		end
		ser <= 1'b1;
		sup_low <= 1'b1;
		chk_state();
		i2c_read(8'h85, 1, q);
		chk(q[0], cm[5]);
		// save started from the serial side; the power cycle below cuts it short
		i2c_write({adr(1'b0), 8'h81, cm[1] | 8'h20}, n);
		chk(n, 3);
		apb(1'b0, csc_pkg::APB_STATUS, 0, d, e);
		chk(d[4], 1'b1);
		// power cycle in mid-run brings back the factory store
		sup_low <= 1'b0;
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		load_factory();
		repeat (4) @(posedge mclk);
		check_factory();
		finish_test();
	end

	// a hang is cut short well above the expected run of about 8000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		finish_test();
	end
endmodule // csc_top_test
